// file: bcr_control_reg.sv
// measurement and power control register of the backup controller
// assumes: the management port front end decodes transfers on i_ref_clk and
// presents one-cycle read and write strobes; engine handshakes are same-clock
//
// Overview of operation
// - a read/write control register at command code 0, 11 bits wide, resets to all zero.
// - writing one to bit 0 requests a measurement and the bit clears once one has begun.
// - writing one to bit 2 stops a running measurement and the bit clears once it has stopped.
// - bit 1 set routes the general input through its buffer, clear measures it unbuffered.
// - bit 3 picks the capacitance scale, and the small scale reports 100 times finer.
// - while bit 4 is set the shunt overvoltage regulators stay inactive.
// - while bit 5 is set the inrush switch controller is off and its gate drive is held low.
// - while bit 5 is set the converter is forced into backup operation.
// - while bit 6 is set the boost backup converter stays disabled.
// - while bit 7 is set the step-down charger stays disabled.
// - while bit 8 is set the test discharge current is forced on, leaving the charger alone.
`timescale 1ns/10ps
`include "bcr_params.svh"

module bcr_control_reg (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    input  wire logic [`BCR_CMD_W-1:0]  i_cmd,
    input  wire logic [`BCR_DATA_W-1:0] i_wdata,
    output logic      [`BCR_DATA_W-1:0] o_rdata,
    output logic                        o_rd_valid,
    input  wire logic                   i_meas_begun,
    input  wire logic                   i_meas_stopped,
    output logic                        o_meas_start_req,
    output logic                        o_meas_stop_req,
    input  wire logic                   i_gate_req,
    input  wire logic                   i_backup_req,
    input  wire logic [`BCR_DATA_W-1:0] i_cap_raw,
    output logic      [`BCR_DATA_W-1:0] o_cap_value,
    output logic                        o_cap_small,
    output logic                        o_gpi_buf_en,
    output logic                        o_shunt_off,
    output logic                        o_switch_off,
    output logic                        o_gate_drive,
    output logic                        o_backup_mode,
    output logic                        o_boost_off,
    output logic                        o_charger_off,
    output logic                        o_itst_on
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic ctl_hit(input logic [`BCR_CMD_W-1:0] cmd);
        ctl_hit = (cmd == `BCR_CTL_CMD);
    endfunction : ctl_hit

    // saturates instead of wrapping, so a large stack on the fine scale reads full scale
    function automatic logic [`BCR_DATA_W-1:0] fine_scale(input logic [`BCR_DATA_W-1:0] raw);
        logic [`BCR_CAP_PROD_W-1:0] prod;
        prod = `BCR_CAP_PROD_W'(raw) * `BCR_CAP_PROD_W'(`BCR_CAP_FINE_MULT);
        if (prod > `BCR_CAP_PROD_W'(`BCR_CAP_MAX)) begin
            fine_scale = `BCR_CAP_MAX;
        end else begin
            fine_scale = prod[`BCR_DATA_W-1:0];
        end
    endfunction : fine_scale

    // ----------------------------------------------------------------
    // self-clearing request bits
    // ----------------------------------------------------------------
    logic wr_hit;
    logic set_start;
    logic set_stop;
    logic start_bit;
    logic stop_bit;

    assign wr_hit    = i_wr_en && ctl_hit(i_cmd);
    assign set_start = wr_hit && i_wdata[`BCR_BIT_START];
    assign set_stop  = wr_hit && i_wdata[`BCR_BIT_STOP];

    bcr_self_clear_bit u_start_bit (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_set     (set_start),
        .i_done    (i_meas_begun),
        .o_bit     (start_bit)
    );

    bcr_self_clear_bit u_stop_bit (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_set     (set_stop),
        .i_done    (i_meas_stopped),
        .o_bit     (stop_bit)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bcr_pkg::bcr_ctl_t st;
    bcr_pkg::bcr_ctl_t next_st;
    logic [`BCR_CTL_W-1:0] readback;

    always_comb begin
        next_st = st;
        // request bits live in their own flops, the rest here
        readback = st.ctl & `BCR_CTL_LIVE;
        readback[`BCR_BIT_START] = start_bit;
        readback[`BCR_BIT_STOP]  = stop_bit;
        if (wr_hit) begin
            next_st.ctl = i_wdata[`BCR_CTL_W-1:0] & `BCR_CTL_LIVE;
            next_st.ctl[`BCR_BIT_START] = 1'b0;
            next_st.ctl[`BCR_BIT_STOP]  = 1'b0;
        end
        next_st.rd_valid = i_rd_en;
        if (i_rd_en) begin
            next_st.rdata = `BCR_RD_IDLE;
            if (ctl_hit(i_cmd)) begin
                next_st.rdata[`BCR_CTL_W-1:0] = readback;
            end
        end
        // switch forced off wins over any request from the inrush controller
        next_st.gate_drive = i_gate_req && !next_st.ctl[`BCR_BIT_SWITCH_OFF];
        next_st.backup     = i_backup_req || next_st.ctl[`BCR_BIT_SWITCH_OFF];
        if (next_st.ctl[`BCR_BIT_CAP_SCALE]) begin
            next_st.cap_value = fine_scale(i_cap_raw);
        end else begin
            next_st.cap_value = i_cap_raw;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st.ctl        <= `BCR_CTL_RESET;
            st.rdata      <= `BCR_RD_IDLE;
            st.rd_valid   <= 1'b0;
            st.gate_drive <= 1'b0;
            st.backup     <= 1'b0;
            st.cap_value  <= `BCR_RD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_rdata          = st.rdata;
    assign o_rd_valid       = st.rd_valid;
    assign o_meas_start_req = start_bit;
    assign o_meas_stop_req  = stop_bit;
    assign o_cap_value      = st.cap_value;
    assign o_cap_small      = st.ctl[`BCR_BIT_CAP_SCALE];
    assign o_gpi_buf_en     = st.ctl[`BCR_BIT_GPI_BUF];
    assign o_shunt_off      = st.ctl[`BCR_BIT_SHUNT_OFF];
    assign o_switch_off     = st.ctl[`BCR_BIT_SWITCH_OFF];
    assign o_gate_drive     = st.gate_drive;
    assign o_backup_mode    = st.backup;
    assign o_boost_off      = st.ctl[`BCR_BIT_BOOST_OFF];
    assign o_charger_off    = st.ctl[`BCR_BIT_CHG_OFF];
    assign o_itst_on        = st.ctl[`BCR_BIT_ITST_ON];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_write_lands: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_hit |=> (o_boost_off == $past(i_wdata[`BCR_BIT_BOOST_OFF]))
               && (o_charger_off == $past(i_wdata[`BCR_BIT_CHG_OFF]))
               && (o_itst_on == $past(i_wdata[`BCR_BIT_ITST_ON]))
    ) else $error("control write did not land");

    a_hold_no_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !wr_hit |=> $stable(st.ctl)
    ) else $error("control bits changed without a write");

    a_start_sets: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        set_start |=> o_meas_start_req
    ) else $error("start request lost");

    a_start_clears: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_meas_start_req && i_meas_begun && !set_start |=> !o_meas_start_req
    ) else $error("start bit did not clear on begin");

    a_start_holds: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_meas_start_req && !i_meas_begun |=> o_meas_start_req
    ) else $error("start bit dropped early");

    a_stop_cycle: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        set_stop ##1 (!i_meas_stopped && !set_stop) [*2] |=> o_meas_stop_req
    ) else $error("stop request dropped before stop");

    a_stop_clears: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_meas_stop_req && i_meas_stopped && !set_stop |=> !o_meas_stop_req
    ) else $error("stop bit did not clear");

    a_gpi_buffer: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_hit |=> o_gpi_buf_en == $past(i_wdata[`BCR_BIT_GPI_BUF])
    ) else $error("buffer select wrong");

    a_cap_fine: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (next_st.ctl[`BCR_BIT_CAP_SCALE] && i_cap_raw < 16'h0100)
        |=> o_cap_value == $past(i_cap_raw) * 16'h0064
    ) else $error("fine capacitance scale wrong");

    a_shunt_off: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_hit && i_wdata[`BCR_BIT_SHUNT_OFF] |=> o_shunt_off
    ) else $error("shunt not disabled");

    a_gate_low: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_switch_off |-> !o_gate_drive
    ) else $error("gate driven while switch off");

    a_backup_forced: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_switch_off |-> o_backup_mode
    ) else $error("backup not forced");

    a_boost_off: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_boost_off && !wr_hit |=> o_boost_off
    ) else $error("boost re-enabled without a write");

    a_charger_off: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_hit && i_wdata[`BCR_BIT_CHG_OFF] |=> o_charger_off
    ) else $error("charger not disabled");

    a_itst_alone: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_hit && i_wdata[`BCR_BIT_ITST_ON] && !i_wdata[`BCR_BIT_CHG_OFF]
        |=> o_itst_on && !o_charger_off
    ) else $error("test current touched the charger");

    a_spare_zero: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_rd_valid |-> o_rdata[`BCR_DATA_W-1:`BCR_BIT_ITST_ON+1] == 7'h00
    ) else $error("spare bits read non-zero");

    a_read_valid: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_rd_en |=> o_rd_valid
    ) else $error("read strobe not answered");

    a_valid_pulse: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !i_rd_en |=> !o_rd_valid
    ) else $error("read valid without a read");

    a_read_unmapped: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_rd_en && !ctl_hit(i_cmd) |=> o_rdata == `BCR_RD_IDLE
    ) else $error("unmapped command read non-zero");

    a_read_low_bits: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_rd_en && ctl_hit(i_cmd) |=> o_rdata[`BCR_BIT_STOP:`BCR_BIT_START]
            == $past({o_meas_stop_req, o_gpi_buf_en, o_meas_start_req})
    ) else $error("request bits read back wrong");

    a_read_levels: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_rd_en && ctl_hit(i_cmd) |=> o_rdata[`BCR_BIT_ITST_ON:`BCR_BIT_CAP_SCALE]
            == $past({o_itst_on, o_charger_off, o_boost_off,
                      o_switch_off, o_shunt_off, o_cap_small})
    ) else $error("control levels read back wrong");

    a_stop_sets: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        set_stop |=> o_meas_stop_req
    ) else $error("stop request lost");

    a_stop_holds: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_meas_stop_req && !i_meas_stopped |=> o_meas_stop_req
    ) else $error("stop bit dropped early");

    a_levels_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_hit |=> (o_cap_small == $past(i_wdata[`BCR_BIT_CAP_SCALE]))
               && (o_shunt_off == $past(i_wdata[`BCR_BIT_SHUNT_OFF]))
               && (o_switch_off == $past(i_wdata[`BCR_BIT_SWITCH_OFF]))
    ) else $error("scale, shunt or switch write did not land");

    a_cap_coarse: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !next_st.ctl[`BCR_BIT_CAP_SCALE] |=> o_cap_value == $past(i_cap_raw)
    ) else $error("coarse capacitance scale wrong");

    a_cap_saturate: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        next_st.ctl[`BCR_BIT_CAP_SCALE]
        && (32'(i_cap_raw) * 32'(`BCR_CAP_FINE_MULT) > 32'(`BCR_CAP_MAX))
        |=> o_cap_value == `BCR_CAP_MAX
    ) else $error("fine capacitance did not saturate");

    a_gate_follows: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !next_st.ctl[`BCR_BIT_SWITCH_OFF] |=> o_gate_drive == $past(i_gate_req)
    ) else $error("gate drive ignores its request");

    a_backup_follows: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !next_st.ctl[`BCR_BIT_SWITCH_OFF] |=> o_backup_mode == $past(i_backup_req)
    ) else $error("backup mode ignores its request");

endmodule : bcr_control_reg

// file: bcr_params.svh
// constants of the measurement and power control register
// assumes: included by the package and the design modules by bare name
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH

// ----------------------------------------------------------------
// register access
// ----------------------------------------------------------------
`define BCR_CMD_W          8
`define BCR_DATA_W         16
`define BCR_CTL_CMD        8'h00
`define BCR_CTL_W          11
`define BCR_CTL_RESET      11'h000
`define BCR_CTL_LIVE       11'h1ff
`define BCR_RD_IDLE        16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BCR_BIT_START      0
`define BCR_BIT_GPI_BUF    1
`define BCR_BIT_STOP       2
`define BCR_BIT_CAP_SCALE  3
`define BCR_BIT_SHUNT_OFF  4
`define BCR_BIT_SWITCH_OFF 5
`define BCR_BIT_BOOST_OFF  6
`define BCR_BIT_CHG_OFF    7
`define BCR_BIT_ITST_ON    8

// ----------------------------------------------------------------
// capacitance scaling
// ----------------------------------------------------------------
`define BCR_CAP_FINE_MULT  7'h64
`define BCR_CAP_PROD_W     23
`define BCR_CAP_MAX        16'hffff

`endif

// file: bcr_pkg.sv
// types of the measurement and power control register
// assumes: bcr_params.svh is on the include path
`include "bcr_params.svh"

package bcr_pkg;

    // ----------------------------------------------------------------
    // self-clearing request bit
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        bcr_req_idle,
        bcr_req_asked
    } bcr_req_state_t;

    typedef struct packed {
        bcr_req_state_t st;
    } bcr_req_t;

    // ----------------------------------------------------------------
    // control register state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`BCR_CTL_W-1:0]  ctl;
        logic [`BCR_DATA_W-1:0] rdata;
        logic                   rd_valid;
        logic                   gate_drive;
        logic                   backup;
        logic [`BCR_DATA_W-1:0] cap_value;
    } bcr_ctl_t;

endpackage : bcr_pkg

// file: bcr_self_clear_bit.sv
// one request bit that software sets and the engine clears
// assumes: i_set and i_done come from logic on i_ref_clk
`timescale 1ns/10ps
`include "bcr_params.svh"

module bcr_self_clear_bit (
    input  wire logic i_ref_clk,
    input  wire logic i_nrst,
    input  wire logic i_set,
    input  wire logic i_done,
    output logic      o_bit
);

    bcr_pkg::bcr_req_t st;
    bcr_pkg::bcr_req_t next_st;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // a set in the same cycle as done wins, so a fresh request is never lost
    always_comb begin
        next_st = st;
        case (st.st)
            bcr_pkg::bcr_req_idle: begin
                if (i_set) begin
                    next_st.st = bcr_pkg::bcr_req_asked;
                end
            end
            bcr_pkg::bcr_req_asked: begin
                if (!i_set && i_done) begin
                    next_st.st = bcr_pkg::bcr_req_idle;
                end
            end
            default: begin
                next_st.st = bcr_pkg::bcr_req_idle;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st.st <= bcr_pkg::bcr_req_idle;
        end else begin
            st <= next_st;
        end
    end

    assign o_bit = (st.st == bcr_pkg::bcr_req_asked);

endmodule : bcr_self_clear_bit

// file: bcr_control_reg_tb.sv
// self-checking bench for the measurement and power control register
// assumes: bcr_params.svh on the include path; the bench drives every port itself
`timescale 1ns/10ps
`include "bcr_params.svh"

`define CHECK_EQ(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp); \
        end \
    end

module bcr_control_reg_tb;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                   i_ref_clk;
    logic                   i_nrst;
    logic                   i_wr_en;
    logic                   i_rd_en;
    logic [`BCR_CMD_W-1:0]  i_cmd;
    logic [`BCR_DATA_W-1:0] i_wdata;
    logic [`BCR_DATA_W-1:0] o_rdata;
    logic                   o_rd_valid;
    logic                   i_meas_begun;
    logic                   i_meas_stopped;
    logic                   o_meas_start_req;
    logic                   o_meas_stop_req;
    logic                   i_gate_req;
    logic                   i_backup_req;
    logic [`BCR_DATA_W-1:0] i_cap_raw;
    logic [`BCR_DATA_W-1:0] o_cap_value;
    logic                   o_cap_small;
    logic                   o_gpi_buf_en;
    logic                   o_shunt_off;
    logic                   o_switch_off;
    logic                   o_gate_drive;
    logic                   o_backup_mode;
    logic                   o_boost_off;
    logic                   o_charger_off;
    logic                   o_itst_on;
    logic [8:0]             ctl_vec;
    int                     miscompares;
    int                     n_tests;
    int                     cycles;

    // control levels gathered in register bit order
    assign ctl_vec = {o_itst_on, o_charger_off, o_boost_off, o_switch_off, o_shunt_off,
                      o_cap_small, o_meas_stop_req, o_gpi_buf_en, o_meas_start_req};

    bcr_control_reg i_bcr_control_reg (
        .i_ref_clk        (i_ref_clk),
        .i_nrst           (i_nrst),
        .i_wr_en          (i_wr_en),
        .i_rd_en          (i_rd_en),
        .i_cmd            (i_cmd),
        .i_wdata          (i_wdata),
        .o_rdata          (o_rdata),
        .o_rd_valid       (o_rd_valid),
        .i_meas_begun     (i_meas_begun),
        .i_meas_stopped   (i_meas_stopped),
        .o_meas_start_req (o_meas_start_req),
        .o_meas_stop_req  (o_meas_stop_req),
        .i_gate_req       (i_gate_req),
        .i_backup_req     (i_backup_req),
        .i_cap_raw        (i_cap_raw),
        .o_cap_value      (o_cap_value),
        .o_cap_small      (o_cap_small),
        .o_gpi_buf_en     (o_gpi_buf_en),
        .o_shunt_off      (o_shunt_off),
        .o_switch_off     (o_switch_off),
        .o_gate_drive     (o_gate_drive),
        .o_backup_mode    (o_backup_mode),
        .o_boost_off      (o_boost_off),
        .o_charger_off    (o_charger_off),
        .o_itst_on        (o_itst_on)
    );

    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    initial i_ref_clk = 1'b0;
    always #5 i_ref_clk = ~i_ref_clk;

    // the sequence needs about 120 cycles; the margin is generous
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    // one cycle of write strobe and engine pulses, then outputs are settled
    task automatic drive(input logic [7:0] cmd, input logic wr, input logic [15:0] data,
                         input logic begun, input logic stopped);
        @(posedge i_ref_clk);
        i_cmd          <= cmd;
        i_wr_en        <= wr;
        i_wdata        <= data;
        i_meas_begun   <= begun;
        i_meas_stopped <= stopped;
        @(posedge i_ref_clk);
        i_wr_en        <= 1'b0;
        i_meas_begun   <= 1'b0;
        i_meas_stopped <= 1'b0;
        #1;
    endtask : drive

    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_cmd   <= cmd;
        i_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        #1;
        `CHECK_EQ(o_rd_valid, 1'b1)
        `CHECK_EQ(o_rdata, exp)
    endtask : rd

    // cap and gate outputs are registered from their inputs alongside the control bits
    task automatic settle();
        repeat (2) @(posedge i_ref_clk);
        #1;
    endtask : settle

    task automatic report_and_stop();
        $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        miscompares    = 0;
        n_tests        = 0;
        cycles         = 0;
        i_nrst         = 1'b0;
        i_wr_en        = 1'b0;
        i_rd_en        = 1'b0;
        i_cmd          = 8'h00;
        i_wdata        = 16'h0000;
        i_meas_begun   = 1'b0;
        i_meas_stopped = 1'b0;
        i_gate_req     = 1'b0;
        i_backup_req   = 1'b0;
        i_cap_raw      = 16'h0000;
        repeat (8) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        settle();
        `CHECK_EQ({ctl_vec, o_gate_drive, o_backup_mode, o_cap_value}, 27'h0)
        rd(8'h00, 16'h0000);
        // every bit alone, unused ones included
        for (int b = 0; b < 11; b++) begin
            drive(8'h00, 1'b1, 16'h0001 << b, 1'b0, 1'b0);
            `CHECK_EQ(ctl_vec, (b < 9) ? (9'h001 << b) : 9'h000)
            rd(8'h00, (b < 9) ? (16'h0001 << b) : 16'h0000);
            if (b == 0 || b == 2) begin
                drive(8'h00, 1'b0, 16'h0000, 1'b1, 1'b1);
                `CHECK_EQ(ctl_vec, 9'h000)
            end
        end
        drive(8'h00, 1'b1, 16'hfffa, 1'b0, 1'b0);
        rd(8'h00, 16'h01fa);
        // unmapped command: write ignored, read gives zero
        drive(8'h01, 1'b1, 16'h0000, 1'b0, 1'b0);
        `CHECK_EQ(ctl_vec, 9'h1fa)
        rd(8'h01, 16'h0000);
        // start request: stray done, set against done, wrong done, real done
        drive(8'h00, 1'b1, 16'h0000, 1'b1, 1'b1);
        drive(8'h00, 1'b0, 16'h0000, 1'b1, 1'b0);
        `CHECK_EQ(o_meas_start_req, 1'b0)
        drive(8'h00, 1'b1, 16'h0001, 1'b1, 1'b0);
        `CHECK_EQ(o_meas_start_req, 1'b1)
        drive(8'h00, 1'b0, 16'h0000, 1'b0, 1'b1);
        `CHECK_EQ(o_meas_start_req, 1'b1)
        drive(8'h00, 1'b0, 16'h0000, 1'b1, 1'b0);
        `CHECK_EQ(o_meas_start_req, 1'b0)
        // stop request: set against done, wrong done, real done
        drive(8'h00, 1'b1, 16'h0004, 1'b0, 1'b1);
        `CHECK_EQ(o_meas_stop_req, 1'b1)
        drive(8'h00, 1'b0, 16'h0000, 1'b1, 1'b0);
        `CHECK_EQ(o_meas_stop_req, 1'b1)
        drive(8'h00, 1'b0, 16'h0000, 1'b0, 1'b1);
        `CHECK_EQ(o_meas_stop_req, 1'b0)
        // inrush switch forced off and backup operation
        @(posedge i_ref_clk);
        i_gate_req <= 1'b1;
        settle();
        `CHECK_EQ({o_gate_drive, o_backup_mode}, 2'b10)
        drive(8'h00, 1'b1, 16'h0020, 1'b0, 1'b0);
        settle();
        `CHECK_EQ({o_switch_off, o_gate_drive, o_backup_mode}, 3'b101)
        drive(8'h00, 1'b1, 16'h0000, 1'b0, 1'b0);
        @(posedge i_ref_clk);
        i_backup_req <= 1'b1;
        settle();
        `CHECK_EQ({o_gate_drive, o_backup_mode}, 2'b11)
        @(posedge i_ref_clk);
        i_backup_req <= 1'b0;
        // capacitance scale, with the saturation boundary
        i_cap_raw <= 16'h0010;
        settle();
        `CHECK_EQ(o_cap_value, 16'h0010)
        drive(8'h00, 1'b1, 16'h0008, 1'b0, 1'b0);
        settle();
        `CHECK_EQ(o_cap_value, 16'h0640)
        @(posedge i_ref_clk);
        i_cap_raw <= 16'h028f;
        settle();
        `CHECK_EQ(o_cap_value, 16'hffdc)
        @(posedge i_ref_clk);
        i_cap_raw <= 16'h0290;
        settle();
        `CHECK_EQ(o_cap_value, 16'hffff)
        // reset in mid-run clears everything
        drive(8'h00, 1'b1, 16'h01fd, 1'b0, 1'b0);
        `CHECK_EQ(ctl_vec, 9'h1fd)
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        `CHECK_EQ({ctl_vec, o_backup_mode, o_cap_value}, 26'h0)
        @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(8'h00, 16'h0000);
        report_and_stop();
    end

endmodule : bcr_control_reg_tb
